// >>> rtl/iprm_pkg.sv
// Purpose: shared constants for the interrupt priority and mask core
// Assumes: 32-bit APB register window, eight request levels
// Notes: offsets are byte addresses of aligned words
package iprm_pkg;
	localparam int IPRM_LEVELS = 8;
	localparam logic [11:0] IPRM_OFF_MASK = 12'h000;
	localparam logic [11:0] IPRM_OFF_CMD = 12'h004;
	localparam logic [11:0] IPRM_OFF_STATUS = 12'h008;
	localparam logic [11:0] IPRM_OFF_SERVICE = 12'h00C;
	localparam logic [11:0] IPRM_OFF_ACK = 12'h010;
	localparam logic [7:0] IPRM_MASK_RST = 8'hFF;
	localparam logic [2:0] IPRM_LOWEST_RST = 3'h7;
	// Command word fields
	localparam int IPRM_CMD_LVL_LSB = 0;
	localparam int IPRM_CMD_OP_LSB = 4;
	localparam logic [2:0] IPRM_OP_NSPEC_DONE = 3'h1;
	localparam logic [2:0] IPRM_OP_SPEC_DONE = 3'h2;
	localparam logic [2:0] IPRM_OP_SET_PRIO = 3'h3;
	localparam logic [2:0] IPRM_OP_ROT_SPEC = 3'h4;
	localparam logic [2:0] IPRM_OP_SMM_SET = 3'h5;
	localparam logic [2:0] IPRM_OP_SMM_CLR = 3'h6;
	// Status word fields
	localparam int IPRM_ST_PEND_LSB = 0;
	localparam int IPRM_ST_INSV_LSB = 8;
	localparam int IPRM_ST_LOW_LSB = 16;
	localparam int IPRM_ST_SMM_BIT = 20;
	localparam int IPRM_ST_IRQ_BIT = 21;
	localparam int IPRM_ST_VEC_LSB = 24;
endpackage

// >>> rtl/iprm_core.sv
// Purpose: priority rotation, masking and in-service tracking over APB
// Assumes: request inputs synchronous to pclk, level sensitive
// Notes: APB answers with pready high in the access cycle, no wait
//   Register map, byte offsets of aligned words:
//   0x000 mask, bits 7:0, a one blocks that level
//   0x004 command, write only, reads zero
//     bits 2:0 level, bits 6:4 operation
//     1 non-specific done, 2 specific done, 3 set lowest level
//     4 rotate on specific done, 5 mode set, 6 mode clear
//   0x008 status, read only
//     7:0 pending, 15:8 in service, 18:16 lowest level
//     20 selective-unmask mode, 21 interrupt, 26:24 top level
//   0x00C in-service copy, read only
//   0x010 last acknowledge: 2:0 level, 3 valid pulse
//   Unmapped addresses read zero and raise pslverr
//   Read data is captured in the setup cycle, so it is a
//   snapshot taken one cycle before the access completes
//   Requests are level sensitive: pending follows the pins,
//   so a request dropped while masked leaves nothing behind
//   Acknowledge wins over a same-cycle clear of its own bit
//   A priority change re-ranks at once; nothing in service
//   is cleared or preempted by the change itself
//   Host duties: use specific done after set-priority or in
//   the mode; mask the level in service before entering the
//   mode and clear the mode before unmasking it again
//   Only pstrb[0] is looked at; all fields sit in byte 0
//   Low clk_en freezes state and drops bus and acknowledge
`timescale 1ns/10ps
module iprm_core
	import iprm_pkg::*;
#(
	parameter int LEVELS = IPRM_LEVELS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] request_input,
	input wire logic acknowledge_pulse,
	output logic irq_out,
	output logic [2:0] ack_level,
	output logic ack_valid
);

	initial begin
		if (LEVELS != 8) begin
			$error("iprm_core supports exactly eight levels");
		end
		// Decoder compares whole addresses, so offsets must be aligned
		if (IPRM_OFF_MASK[1:0] != 2'h0 || IPRM_OFF_CMD[1:0] != 2'h0 ||
			IPRM_OFF_STATUS[1:0] != 2'h0 ||
			IPRM_OFF_SERVICE[1:0] != 2'h0 ||
			IPRM_OFF_ACK[1:0] != 2'h0) begin
			$error("iprm_core register offsets must be word aligned");
		end
		if (IPRM_CMD_OP_LSB < IPRM_CMD_LVL_LSB + 3) begin
			$error("iprm_core command fields overlap");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State
	logic [7:0] level_mask_reg_q;
	logic [7:0] pending_request_reg_q;
	logic [7:0] in_service_reg_q;
	logic [2:0] lowest_q;
	logic selective_unmask_mode_q;
	logic [2:0] ack_level_q;
	logic ack_valid_q;
	logic [31:0] prdata_q;

	////////////////////////////////////////////////////////////////////////
	// Rotate a vector so that index 0 is the highest-priority level
	// Doubling the vector keeps the rotate a plain shift, no wrap mux
	// The lowest level lands on index 7 after the rotate
	function automatic logic [7:0] rot_to_prio(input logic [7:0] v,
		input logic [2:0] low);
		logic [15:0] dbl;
		logic [2:0] hi;
		dbl = {v, v};
		hi = 3'(low + 3'h1);
		rot_to_prio = 8'(dbl >> hi);
	endfunction

	// Highest-priority set bit: found flag plus level number
	function automatic logic [3:0] pick_top(input logic [7:0] v,
		input logic [2:0] low);
		logic [7:0] r;
		logic [2:0] hi;
		pick_top = 4'h0;
		r = rot_to_prio(v, low);
		hi = 3'(low + 3'h1);
		for (int i = 7; i >= 0; i--) begin
			if (r[i]) begin
				pick_top = {1'b1, 3'(hi + 3'(i))};
			end
		end
	endfunction

	// One-hot decode of a three-bit level field
	function automatic logic [7:0] lvl_onehot(input logic [2:0] lvl);
		lvl_onehot = 8'h01 << lvl;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus decode; slave never waits
	// Writes land on the access edge only, so a stalled setup cycle
	// can never commit a command twice
	wire logic bus_wr = psel && penable && pwrite && clk_en;
	wire logic bus_rd = psel && penable && !pwrite && clk_en;
	wire logic sel_mask = paddr == IPRM_OFF_MASK;
	wire logic sel_cmd = paddr == IPRM_OFF_CMD;
	wire logic sel_status = paddr == IPRM_OFF_STATUS;
	wire logic sel_service = paddr == IPRM_OFF_SERVICE;
	wire logic sel_ack = paddr == IPRM_OFF_ACK;
	wire logic addr_ok = sel_mask | sel_cmd | sel_status | sel_service |
		sel_ack;
	wire logic wr_mask = bus_wr && sel_mask && pstrb[0];
	wire logic wr_cmd = bus_wr && sel_cmd && pstrb[0];
	wire logic [2:0] cmd_lvl = pwdata[IPRM_CMD_LVL_LSB +: 3];
	wire logic [2:0] cmd_op = pwdata[IPRM_CMD_OP_LSB +: 3];
	wire logic [7:0] cmd_hot = lvl_onehot(cmd_lvl);

	////////////////////////////////////////////////////////////////////////
	// Priority resolution
	// Top picks use rotated copies and ranks are offsets from the pointer, so the pointer alone
	// decides the order; no per-level priority storage is needed
	// masking acts after pending register
	logic [7:0] unmasked_pend;
	for (genvar g = 0; g < 8; g++) begin : g_gate
		// Pending still records a masked request
		assign unmasked_pend[g] = pending_request_reg_q[g] &
			~level_mask_reg_q[g];
	end
	wire logic [3:0] top_req = pick_top(unmasked_pend, lowest_q);
	wire logic [3:0] top_isr = pick_top(in_service_reg_q, lowest_q);
	// masked bits invisible in selective-unmask mode
	wire logic [7:0] isr_visible = selective_unmask_mode_q ?
		(in_service_reg_q & ~level_mask_reg_q) : in_service_reg_q;
	wire logic [3:0] top_done = pick_top(isr_visible, lowest_q);
	// Rank of a level: 0 highest, 7 lowest
	wire logic [2:0] rank_req = 3'(top_req[2:0] - lowest_q - 3'h1);
	wire logic [2:0] rank_isr = 3'(top_isr[2:0] - lowest_q - 3'h1);
	// equal or lower than in-service is blocked
	wire logic nested_ok = !top_isr[3] || (rank_req < rank_isr);
	// mode ignores in-service, mask still applies
	wire logic req_eligible = top_req[3] &&
		(selective_unmask_mode_q || nested_ok);
	// output follows live resolution of requests
	assign irq_out = req_eligible;

	////////////////////////////////////////////////////////////////////////
	// Pending register tracks level-sensitive requests
	// withdrawn request drops its pending bit
	wire logic [7:0] pend_d = request_input;
	// acknowledge takes the top eligible level
	wire logic ack_take = acknowledge_pulse && req_eligible && clk_en;
	wire logic [7:0] ack_hot = ack_take ? lvl_onehot(top_req[2:0]) : 8'h00;

	// In-service clears from commands
	// Every command clears at most one bit; none can set one back,
	// which keeps a cleared routine from being revived by software
	logic [7:0] isr_clr;
	always_comb begin
		isr_clr = 8'h00;
		if (wr_cmd) begin
			case (cmd_op)
				IPRM_OP_NSPEC_DONE: isr_clr = top_done[3] ?
					lvl_onehot(top_done[2:0]) : 8'h00;
				IPRM_OP_SPEC_DONE: isr_clr = cmd_hot;
				IPRM_OP_ROT_SPEC: isr_clr = cmd_hot;
				default: isr_clr = 8'h00;
			endcase
		end
	end
	// only acknowledge sets, and it wins over a clear
	wire logic [7:0] isr_d = (in_service_reg_q & ~isr_clr) | ack_hot;

	// Lowest-priority pointer update
	// named level becomes lowest
	wire logic rotate = wr_cmd && (cmd_op == IPRM_OP_SET_PRIO ||
		cmd_op == IPRM_OP_ROT_SPEC);
	wire logic [2:0] lowest_d = rotate ? cmd_lvl : lowest_q;

	// mode only leaves on its clear command
	logic smm_d;
	always_comb begin
		smm_d = selective_unmask_mode_q;
		if (wr_cmd && cmd_op == IPRM_OP_SMM_SET) begin
			smm_d = 1'b1;
		end else if (wr_cmd && cmd_op == IPRM_OP_SMM_CLR) begin
			smm_d = 1'b0;
		end
	end

	wire logic [7:0] mask_d = wr_mask ? pwdata[7:0] : level_mask_reg_q;

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped reads zero with an error
	// Command register is write only and reads as zero
	logic [31:0] rd_d;
	always_comb begin
		rd_d = 32'h0000_0000;
		if (sel_mask) begin
			rd_d[7:0] = level_mask_reg_q;
		end else if (sel_status) begin
			rd_d[IPRM_ST_PEND_LSB +: 8] = pending_request_reg_q;
			rd_d[IPRM_ST_INSV_LSB +: 8] = in_service_reg_q;
			rd_d[IPRM_ST_LOW_LSB +: 3] = lowest_q;
			rd_d[IPRM_ST_SMM_BIT] = selective_unmask_mode_q;
			rd_d[IPRM_ST_IRQ_BIT] = req_eligible;
			rd_d[IPRM_ST_VEC_LSB +: 3] = top_req[2:0];
		end else if (sel_service) begin
			rd_d[7:0] = in_service_reg_q;
		end else if (sel_ack) begin
			rd_d[2:0] = ack_level_q;
			rd_d[3] = ack_valid_q;
		end
	end
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = prdata_q;
	assign ack_level = ack_level_q;
	assign ack_valid = ack_valid_q;

	////////////////////////////////////////////////////////////////////////
	// Registers; clock enable freezes everything
	// Pending has no latch: a request must stand until acknowledged,
	// trading edge capture for a simpler, glitch-free path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_mask_reg_q <= IPRM_MASK_RST;
			pending_request_reg_q <= 8'h00;
			in_service_reg_q <= 8'h00;
			lowest_q <= IPRM_LOWEST_RST;
			selective_unmask_mode_q <= 1'b0;
		end else if (clk_en) begin
			level_mask_reg_q <= mask_d;
			pending_request_reg_q <= pend_d;
			in_service_reg_q <= isr_d;
			lowest_q <= lowest_d;
			selective_unmask_mode_q <= smm_d;
		end
	end

	// Acknowledge result and read data capture
	// Level stays until the next acknowledge so software can still
	// read it after the one-cycle valid pulse has gone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_level_q <= 3'h0;
			ack_valid_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			ack_valid_q <= ack_take;
			if (ack_take) begin
				ack_level_q <= top_req[2:0];
			end
			if (psel && !penable && !pwrite) begin
				prdata_q <= rd_d;
			end
		end
	end

endmodule

// >>> dv/iprm_chk.sv
// Purpose: port checks for iprm_core
// Assumes: bench holds clk_en high
// Notes: pending is mirrored two stages deep
`timescale 1ns/10ps
module iprm_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] request_input,
	input wire logic acknowledge_pulse,
	input wire logic irq_out,
	input wire logic [2:0] ack_level,
	input wire logic ack_valid
);
	logic [7:0] p1_q;
	logic [7:0] p2_q;
	wire take = acknowledge_pulse & irq_out & clk_en;
	wire acc = psel & penable;
	wire mapped = paddr <= 12'h010 && paddr[1:0] == 2'h0;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Pending copy, so the acked level can be judged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p1_q <= 8'h00;
			p2_q <= 8'h00;
		end else begin
			p1_q <= request_input;
			p2_q <= p1_q;
		end
	end
	ack_resp_a: assert property (take |=> ack_valid)
		else $error("taken ack gave no pulse");
	ack_src_a: assert property (ack_valid |-> $past(take))
		else $error("pulse without taken ack");
	ack_refuse_a: assert property (!irq_out |=> !ack_valid)
		else $error("ack taken while idle");
	ack_lvl_a: assert property (ack_valid |-> p2_q[ack_level])
		else $error("acked level not pending");
	idle_irq_a: assert property ($past(request_input) == 8'h00 |-> !irq_out)
		else $error("irq with nothing pending");
	err_map_a: assert property (acc && !mapped |-> pslverr)
		else $error("unmapped access not refused");
	ok_map_a: assert property (acc && mapped |-> !pslverr)
		else $error("mapped access refused");
	rdy_now_a: assert property (acc |-> pready)
		else $error("access stalled");
	cover property (take ##1 ack_valid);
	cover property (acc && pslverr);
	cover property ($rose(irq_out));
endmodule
bind iprm_core iprm_chk iprm_chk_inst (.*);

// >>> dv/iprm_host.sv
// Purpose: host that acknowledges a raised interrupt
// Assumes: en is high for one edge per wanted ack
// Notes: never acks while irq_out is low
`timescale 1ns/10ps
module iprm_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic en,
	input wire logic irq_out,
	output logic acknowledge_pulse
);
	// One-cycle ack, only with a live interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acknowledge_pulse <= 1'b0;
		end else begin
			acknowledge_pulse <= en & irq_out & !acknowledge_pulse;
		end
	end
endmodule

// >>> dv/iprm_core_tb.sv
// Purpose: self-checking run of iprm_core
// Assumes: zero-wait APB slave
// Notes: host model issues the acks
`timescale 1ns/10ps
module iprm_core_tb;
	import iprm_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic clk_en = 1;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] request_input = 8'h00;
	logic en = 0;
	logic acknowledge_pulse;
	logic irq_out;
	logic [2:0] ack_level;
	logic ack_valid;
	logic [31:0] d;
	logic err;
	int num_errors = 0;
	int n_compared = 0;
	iprm_core iprm_core_inst (.*);
	iprm_host iprm_host_inst (.*);
	initial forever #2.5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	// One APB transfer; the wait loop spares us a latency guess
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] v);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		d = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic cmd(input logic [2:0] op, input logic [2:0] l);
		apb(1, IPRM_OFF_CMD, {25'h0, op, 1'b0, l});
	endtask
	task automatic ci(input logic e);
		@(negedge pclk);
		chk({31'h0, irq_out}, {31'h0, e});
		@(posedge pclk);
	endtask
	// Ack one edge of en; pulse is due one cycle after the take
	task automatic ack(input logic [2:0] e);
		en <= 1;
		@(posedge pclk);
		en <= 0;
		repeat (1) @(posedge pclk);
		@(negedge pclk);
		chk({28'h0, ack_valid, ack_level}, {28'h0, 1'b1, e});
		@(posedge pclk);
	endtask
	task automatic tally_and_finish;
		$display("compares %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5000) @(posedge pclk);
		num_errors++;
		tally_and_finish;
	end
	initial begin
		int i;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		apb(0, IPRM_OFF_MASK, 0);
		chk(d, 32'hFF);
		request_input <= 8'h08;
		apb(0, IPRM_OFF_STATUS, 0);
		chk(d & 32'h003700FF, 32'h00070008);
		apb(1, IPRM_OFF_MASK, 32'hF7);
		ci(1);
		ack(3);
		ci(0);
		request_input <= 8'h0E;
		apb(1, IPRM_OFF_MASK, 32'hF1);
		ci(1);
		ack(1);
		ci(0);
		request_input <= 8'h0C;
		cmd(IPRM_OP_NSPEC_DONE, 0);
		ack(2);
		cmd(IPRM_OP_SET_PRIO, 1);
		ci(0);
		cmd(IPRM_OP_ROT_SPEC, 3);
		request_input <= 8'h0E;
		apb(0, IPRM_OFF_STATUS, 0);
		chk(d & 32'h00070F00, 32'h00030400);
		ack(1);
		// Mask own level first, then enter the mode
		apb(1, IPRM_OFF_MASK, 32'hF7);
		ci(0);
		cmd(IPRM_OP_SMM_SET, 0);
		ci(1);
		ack(3);
		apb(0, IPRM_OFF_STATUS, 0);
		chk(d & 32'h00100F00, 32'h00100E00);
		for (i = 1; i < 4; i++) begin
			cmd(IPRM_OP_SPEC_DONE, i[2:0]);
		end
		cmd(IPRM_OP_SMM_CLR, 0);
		apb(0, IPRM_OFF_SERVICE, 0);
		chk(d, 32'h0);
		request_input <= 8'h10;
		apb(1, IPRM_OFF_MASK, 32'hFF);
		request_input <= 8'h00;
		apb(1, IPRM_OFF_MASK, 32'hEF);
		ci(0);
		apb(0, 12'h020, 0);
		chk({err, d[30:0]}, 32'h80000000);
		$display("priority, mask and mode tests done");
		tally_and_finish;
	end
endmodule
